// ### design/e1o_framer.sv
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Overview of operation
// - Channel N high nibble to TS16 bits 1-4
// - Channel N low nibble to TS16 bits 5-8
// - Controller fills unused BCD with 101
// - Controller never sends high ABCD nibble 0000
// - FAS bit 1 from channel 16 unless CRC
// - Channel 16 bits 6-0 fill FAS bits 2-8
// - Controller loads alignment pattern 0011011
// - NFAS bit 1 depends on CRC and mux
// - NFAS bit 2 from channel 17 bit 6
// - NFAS bit 3 carries remote alarm
// - NFAS bits 4-8 carry national bits
// - Controller keeps control bit 7 zero
// - Mux puts sub-multiframe results in spare bits
// - Remote loop sends rx tip/ring out
// - Control bit 4 bypasses HDB3 substitution
// - Maintenance reframes on 8 ms timeout
// - Maintenance reframes above 914 errors/second
// - Control bit 2 enables transmit CRC
// - Digital loop returns serial input
// - Forced reframe only on falling control bit 0
// - Controller holds reframe high two frames
// - Control word arrives in channel 18
`include "e1o_params.svh"
module e1o_framer #(
  parameter int MAINT_WAIT_CYC = (`E1O_CLK_HZ / `E1O_MS_PER_S) * `E1O_MAINT_MS,
  parameter int SECOND_CYC     = `E1O_CLK_HZ
) (
  // Clock and reset.
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // Serial control bus.
  e1o_ctl_if.device       ifc,
  // Line receive side and receiver status.
  input  wire logic       rx_tip_in,
  input  wire logic       rx_ring_in,
  input  wire logic       rx_data_in,
  input  wire logic       frame_sync_in,
  input  wire logic       crc_mf_sync_in,
  input  wire logic       crc_err_in,
  input  wire logic       smf1_result_in,
  input  wire logic       smf2_result_in,
  // Line transmit side and status.
  output logic            line_out_a_out,
  output logic            line_out_b_out,
  output logic            reframe_out,
  output e1o_pkg::e1o_byte_t third_control_word_out
);
  import e1o_pkg::*;

  // Fixed overhead patterns held as named constants so single bits can be picked out.
  localparam logic [5:0] MFA_PAT = `E1O_MFA_PAT;
  localparam logic [7:0] TS16_F0 = `E1O_TS16_F0;

  e1o_byte_t  sig_mem [16];
  e1o_byte_t  fas_reg;
  e1o_byte_t  nfas_reg;
  e1o_byte_t  third_control_word_reg;
  e1o_byte_t  shift_reg;
  e1o_byte_t  shift_next;
  e1o_byte_t  cnt_reg;
  e1o_byte_t  cnt_cur;
  e1o_frame_t mf_reg;
  e1o_frame_t mf_cur;
  e1o_kind_t  kind;
  logic [4:0] ts;
  logic [2:0] bp;
  logic [2:0] bsel;
  logic [3:0] crc_reg;
  logic [3:0] crc_res_reg;
  logic       line_bit;
  logic       cbit;
  logic [3:0] d_reg;
  logic [3:0] d_next;
  logic [3:0] v_reg;
  logic [3:0] v_next;
  logic       pol_reg;
  logic       par_reg;
  logic       pol_now;
  logic       par_after;
  logic       force_reframe_prev_reg;
  logic [31:0] wait_cnt_reg;
  logic [31:0] sec_cnt_reg;
  logic [15:0] err_cnt_reg;
  logic       maint_fire;
  logic       err_fire;
  logic       force_reframe_fall;

  // One CRC-4 step, polynomial x^4 + x + 1, message shifted in MSB first.
  function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic b);
    logic fb;
    fb = c[3] ^ b;
    crc4_step = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
  endfunction : crc4_step

  // Bus position of the bit being handled now; the frame pulse marks bit 0.
  always_comb begin
    mf_cur = ifc.frame_pulse ? mf_reg + 4'h1 : mf_reg;
    cnt_cur = ifc.frame_pulse ? 8'h00 : cnt_reg + 8'h01;
    ts = cnt_cur[7:3];
    bp = cnt_cur[2:0];
    bsel = `E1O_LAST_BIT - bp;
    shift_next = {shift_reg[6:0], ifc.ctl_bit};
    kind = mf_cur[0] ? E1O_NFAS_FRAME : E1O_FAS_FRAME;
  end

  // Bus and multiframe counters advance on each bit strobe.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= 8'h00;
      mf_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (ifc.bit_en) begin
      cnt_reg <= cnt_cur;
      mf_reg <= mf_cur;
      shift_reg <= shift_next;
    end
  end

  // Completed control bytes land in the channel store on their last bit.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 16; i++) begin
        sig_mem[i] <= `E1O_SIG_RST;
      end
      fas_reg <= `E1O_FAS_RST;
      nfas_reg <= `E1O_NFAS_RST;
      third_control_word_reg <= `E1O_THIRD_CONTROL_WORD_RST;
    end else if (ifc.bit_en && bp == `E1O_LAST_BIT) begin
      if (ts != 5'h00 && ts <= `E1O_CH_SIG_LAST) begin
        sig_mem[ts[3:0]] <= shift_next;
      end
      if (ts == `E1O_CH_FAS) begin
        fas_reg <= shift_next;
      end
      if (ts == `E1O_CH_NFAS) begin
        nfas_reg <= shift_next;
      end
      if (ts == `E1O_CH_THIRD_CONTROL_WORD) begin
        third_control_word_reg <= shift_next;
      end
    end
  end

  // Line bit selection for timeslot 0, timeslot 16 and payload.
  always_comb begin
    line_bit = ifc.data_bit;
    cbit = 1'b0;
    if (ts == `E1O_TS_ALIGN) begin
      if (kind == E1O_FAS_FRAME) begin
        if (bp == 3'h0) begin
          if (third_control_word_reg[`E1O_M3_CRC]) begin
            line_bit = crc_res_reg[2'h3 - mf_cur[2:1]];
            cbit = 1'b1;
          end else begin
            line_bit = fas_reg[7];
          end
        end else begin
          line_bit = fas_reg[bsel];
        end
      end else if (bp == 3'h0) begin
        if (!third_control_word_reg[`E1O_M3_CRC]) begin
          line_bit = nfas_reg[7];
        end else if (mf_cur == `E1O_FR_SI1 || mf_cur == `E1O_FR_SI2) begin
          if (third_control_word_reg[`E1O_M3_MUX]) begin
            line_bit = (mf_cur == `E1O_FR_SI1) ? smf1_result_in : smf2_result_in;
          end else begin
            line_bit = nfas_reg[7];
          end
        end else begin
          line_bit = MFA_PAT[`E1O_MFA_TOP - mf_cur[3:1]];
        end
      end else begin
        line_bit = nfas_reg[bsel];
      end
    end else if (ts == `E1O_TS_SIG) begin
      if (mf_cur == `E1O_FR_MF0) begin
        line_bit = TS16_F0[bsel];
      end else begin
        line_bit = sig_mem[mf_cur][bsel];
      end
    end
  end

  // CRC over each sub-multiframe; C bits count as zero, result used next time.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      crc_reg <= 4'h0;
      crc_res_reg <= 4'h0;
    end else if (ifc.bit_en) begin
      if (ifc.frame_pulse && mf_cur[2:0] == 3'h0) begin
        crc_res_reg <= crc_reg;
        crc_reg <= crc4_step(4'h0, line_bit & ~cbit);
      end else begin
        crc_reg <= crc4_step(crc_reg, line_bit & ~cbit);
      end
    end
  end

  // HDB3 look-ahead: four bits of delay let a B pulse go in before the zeros.
  always_comb begin
    pol_now = v_reg[3] ? pol_reg : ~pol_reg;
    par_after = d_reg[3] ? (v_reg[3] ? 1'b0 : ~par_reg) : par_reg;
    d_next = {d_reg[2:0], line_bit};
    v_next = {v_reg[2:0], 1'b0};
    if (!third_control_word_reg[`E1O_M3_BYP] && !line_bit && d_reg[2:0] == 3'h0) begin
      d_next[0] = 1'b1;
      v_next[0] = 1'b1;
      d_next[3] = ~par_after;
    end
  end

  // Delay line and pulse polarity state.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      d_reg <= 4'h0;
      v_reg <= 4'h0;
      pol_reg <= 1'b0;
      par_reg <= 1'b0;
    end else if (ifc.bit_en) begin
      d_reg <= d_next;
      v_reg <= v_next;
      par_reg <= par_after;
      if (d_reg[3]) begin
        pol_reg <= pol_now;
      end
    end
  end

  // Line outputs; the remote loop follows the receive pins every clock.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      line_out_a_out <= 1'b0;
      line_out_b_out <= 1'b0;
    end else if (third_control_word_reg[`E1O_M3_LOOP]) begin
      line_out_a_out <= rx_tip_in;
      line_out_b_out <= rx_ring_in;
    end else if (ifc.bit_en) begin
      line_out_a_out <= d_reg[3] & pol_now;
      line_out_b_out <= d_reg[3] & ~pol_now;
    end
  end

  // Serial output stream, replaced by the serial input in digital loop.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ifc.data_ret <= 1'b0;
    end else if (ifc.bit_en) begin
      ifc.data_ret <= third_control_word_reg[`E1O_M3_DG] ? ifc.data_bit : rx_data_in;
    end
  end

  // Maintenance timers; receive CRC checking elsewhere never depends on bit 2.
  always_comb begin
    maint_fire = third_control_word_reg[`E1O_M3_MAINT] && wait_cnt_reg >= 32'(MAINT_WAIT_CYC - 1);
    err_fire = third_control_word_reg[`E1O_M3_MAINT] && err_cnt_reg > 16'(`E1O_ERR_LIMIT);
    force_reframe_fall = force_reframe_prev_reg & ~third_control_word_reg[`E1O_M3_FORCE_REFRAME];
  end

  // Wait for CRC multiframe sync after frame sync.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_cnt_reg <= 32'h0;
    end else if (!third_control_word_reg[`E1O_M3_MAINT] || !frame_sync_in || crc_mf_sync_in || maint_fire) begin
      wait_cnt_reg <= 32'h0;
    end else begin
      wait_cnt_reg <= wait_cnt_reg + 32'h1;
    end
  end

  // One-second window for CRC errors; an error on the boundary starts the next count.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_cnt_reg <= 32'h0;
      err_cnt_reg <= 16'h0;
    end else begin
      if (sec_cnt_reg >= 32'(SECOND_CYC - 1) || err_fire) begin
        sec_cnt_reg <= (sec_cnt_reg >= 32'(SECOND_CYC - 1)) ? 32'h0 : sec_cnt_reg + 32'h1;
        err_cnt_reg <= {15'h0, crc_err_in};
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h1;
        err_cnt_reg <= err_cnt_reg + {15'h0, crc_err_in & ~&err_cnt_reg};
      end
    end
  end

  // Reframe pulse and visible control word.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      force_reframe_prev_reg <= 1'b0;
      reframe_out <= 1'b0;
      third_control_word_out <= `E1O_THIRD_CONTROL_WORD_RST;
    end else begin
      force_reframe_prev_reg <= third_control_word_reg[`E1O_M3_FORCE_REFRAME];
      reframe_out <= force_reframe_fall | maint_fire | err_fire;
      third_control_word_out <= third_control_word_reg;
    end
  end
endmodule : e1o_framer

// ### common/e1o_params.svh
`ifndef E1O_PARAMS_SVH
`define E1O_PARAMS_SVH

// Control-stream channel numbers and line timeslots.
`define E1O_CH_SIG_LAST 5'h0f
`define E1O_CH_FAS      5'h10
`define E1O_CH_NFAS     5'h11
`define E1O_CH_THIRD_CONTROL_WORD     5'h12
`define E1O_TS_ALIGN    5'h00
`define E1O_TS_SIG      5'h10

// Third control word bit positions.
`define E1O_M3_RSVD  7
`define E1O_M3_MUX   6
`define E1O_M3_LOOP  5
`define E1O_M3_BYP   4
`define E1O_M3_MAINT 3
`define E1O_M3_CRC   2
`define E1O_M3_DG    1
`define E1O_M3_FORCE_REFRAME  0

// Multiframe positions and fixed overhead patterns.
`define E1O_FR_SI1    4'hd
`define E1O_FR_SI2    4'hf
`define E1O_FR_MF0    4'h0
`define E1O_MFA_PAT   6'h0b
`define E1O_MFA_TOP   3'h5
`define E1O_TS16_F0   8'h0b
`define E1O_LAST_BIT  3'h7

// Controller reset values for the outgoing channels.
`define E1O_SIG_RST   8'hdd
`define E1O_FAS_RST   8'h9b
`define E1O_NFAS_RST  8'hdf
`define E1O_THIRD_CONTROL_WORD_RST  8'h00
`define E1O_ABCD_FILL 4'hd
`define E1O_IDLE_CH   8'hff

// Controller register map and timing.
`define E1O_ADDR_STATUS 5'h1f
`define E1O_HOLD_FRAMES 2'h2
`define E1O_BIT_DIV     24

// Clock and maintenance timing.
`define E1O_CLK_HZ    50000000
`define E1O_MAINT_MS  8
`define E1O_MS_PER_S  1000
`define E1O_ERR_LIMIT 914

`endif

// ### common/e1o_pkg.sv
package e1o_pkg;
  typedef logic [7:0] e1o_byte_t;
  typedef logic [4:0] e1o_addr_t;
  typedef logic [3:0] e1o_frame_t;
  typedef enum logic {E1O_FAS_FRAME, E1O_NFAS_FRAME} e1o_kind_t;
endpackage : e1o_pkg

// ### common/e1o_ctl_if.sv
`timescale 1ns/100ps
interface e1o_ctl_if;
  logic bit_en;
  logic frame_pulse;
  logic ctl_bit;
  logic data_bit;
  logic data_ret;

  // Controller drives the serial bus timing and both input streams.
  modport host (
    output bit_en,
    output frame_pulse,
    output ctl_bit,
    output data_bit,
    input  data_ret
  );

  // Framer samples the bus and returns the serial output stream.
  modport device (
    input  bit_en,
    input  frame_pulse,
    input  ctl_bit,
    input  data_bit,
    output data_ret
  );
endinterface : e1o_ctl_if

// ### design/e1o_controller.sv
`timescale 1ns/100ps
`include "e1o_params.svh"
module e1o_controller #(
  parameter int BIT_DIV = `E1O_BIT_DIV
) (
  // Clock and reset.
  input  wire logic          ref_clk_in,
  input  wire logic          nrst_in,
  // Software register port.
  input  e1o_pkg::e1o_addr_t addr_in,
  input  e1o_pkg::e1o_byte_t wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output e1o_pkg::e1o_byte_t rdata_out,
  // Payload streams.
  input  wire logic          tx_data_in,
  output logic               rx_data_out,
  // Serial control bus.
  e1o_ctl_if.host            ifc
);
  import e1o_pkg::*;

  e1o_byte_t  ch_mem [32];
  e1o_byte_t  cnt_reg;
  e1o_byte_t  cur_byte;
  e1o_byte_t  wr_val;
  logic [7:0] div_reg;
  logic       tick;
  logic [1:0] hold_reg;
  logic       busy_reg;

  // Bit strobe divider; the bus rate is an approximation of the line rate.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Channel being sent in the next bit slot.
  always_comb begin
    tick = div_reg >= 8'(BIT_DIV - 1);
    cur_byte = ch_mem[cnt_reg[7:3]];
    wr_val = wdata_in;
    if (addr_in != 5'h00 && addr_in <= `E1O_CH_SIG_LAST && wdata_in[7:4] == 4'h0) begin
      wr_val[7:4] = `E1O_ABCD_FILL;
    end
    if (addr_in == `E1O_CH_THIRD_CONTROL_WORD) begin
      wr_val[`E1O_M3_RSVD] = 1'b0;
    end
  end

  // Channel store; reset values give the far end valid overhead from the start.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 32; i++) begin
        ch_mem[i] <= `E1O_IDLE_CH;
      end
      for (int i = 1; i < 16; i++) begin
        ch_mem[i] <= `E1O_SIG_RST;
      end
      ch_mem[`E1O_CH_FAS] <= `E1O_FAS_RST;
      ch_mem[`E1O_CH_NFAS] <= `E1O_NFAS_RST;
      ch_mem[`E1O_CH_THIRD_CONTROL_WORD] <= `E1O_THIRD_CONTROL_WORD_RST;
    end else if (wr_in && addr_in != 5'h00 && addr_in <= `E1O_CH_THIRD_CONTROL_WORD) begin
      ch_mem[addr_in] <= wr_val;
    end else if (tick && cnt_reg == 8'hff && hold_reg == `E1O_HOLD_FRAMES) begin
      ch_mem[`E1O_CH_THIRD_CONTROL_WORD][`E1O_M3_FORCE_REFRAME] <= 1'b0;
    end
  end

  // Counts frame starts while the reframe bit is high.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_reg <= 2'h0;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= ch_mem[`E1O_CH_THIRD_CONTROL_WORD][`E1O_M3_FORCE_REFRAME];
      if (!ch_mem[`E1O_CH_THIRD_CONTROL_WORD][`E1O_M3_FORCE_REFRAME]) begin
        hold_reg <= 2'h0;
      end else if (tick && cnt_reg == 8'h00 && hold_reg != `E1O_HOLD_FRAMES) begin
        hold_reg <= hold_reg + 2'h1;
      end
    end
  end

  // Serialiser: MSB first, channel 18 after channels 16 and 17.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= 8'h00;
      ifc.bit_en <= 1'b0;
      ifc.frame_pulse <= 1'b0;
      ifc.ctl_bit <= 1'b0;
      ifc.data_bit <= 1'b0;
      rx_data_out <= 1'b0;
    end else begin
      ifc.bit_en <= tick;
      // The frame pulse lasts one cycle, beside the bit strobe of bit 0 only.
      ifc.frame_pulse <= tick && cnt_reg == 8'h00;
      if (tick) begin
        cnt_reg <= cnt_reg + 8'h01;
        ifc.ctl_bit <= cur_byte[`E1O_LAST_BIT - cnt_reg[2:0]];
        ifc.data_bit <= tx_data_in;
      end
      if (ifc.bit_en) begin
        rx_data_out <= ifc.data_ret;
      end
    end
  end

  // Register read data, one cycle after the strobe.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (addr_in == `E1O_ADDR_STATUS) begin
        rdata_out <= {7'h00, busy_reg};
      end else if (addr_in != 5'h00 && addr_in <= `E1O_CH_THIRD_CONTROL_WORD) begin
        rdata_out <= ch_mem[addr_in];
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule : e1o_controller

// ### tb/e1o_props.sv
`timescale 1ns/100ps
module e1o_props #(
  parameter int BIT_DIV = 24
) (
  // Clock and reset.
  input wire logic           ref_clk_in,
  input wire logic           nrst_in,
  // Serial bus and framer status.
  input wire logic           bit_en,
  input wire logic           frame_pulse,
  input wire logic           ctl_bit,
  input wire logic           data_bit,
  input wire logic           data_ret,
  input wire logic           reframe_out,
  input e1o_pkg::e1o_byte_t  third_control_word_out
);
  import e1o_pkg::*;
  logic [15:0] gap_reg;
  logic [8:0]  bits_reg;
  logic        bseen_reg;
  logic        fseen_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // Spacing counters; the first gap after reset has no reference, so it is not judged.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_reg <= '0;
      bits_reg <= '0;
      bseen_reg <= 1'b0;
      fseen_reg <= 1'b0;
    end else begin
      gap_reg <= bit_en ? 16'h0000 : gap_reg + 16'h0001;
      bseen_reg <= bseen_reg | bit_en;
      fseen_reg <= fseen_reg | frame_pulse;
      if (frame_pulse) begin
        bits_reg <= '0;
      end else if (bit_en) begin
        bits_reg <= bits_reg + 9'h001;
      end
    end
  end

  AST_FRAME_ON_BIT: assert property (frame_pulse |-> bit_en)
    else $error("frame pulse without bit enable");
  AST_BIT_PERIOD: assert property (bit_en && bseen_reg |-> gap_reg == 16'(BIT_DIV - 1))
    else $error("bit enable spacing wrong");
  AST_FRAME_LEN: assert property (frame_pulse && fseen_reg |-> bits_reg == 9'h0ff)
    else $error("frame is not 256 bits long");
  AST_RET_HOLD: assert property (!bit_en |=> $stable(data_ret))
    else $error("serial output moved between bits");
  AST_DG_LOOP: assert property (bit_en && third_control_word_out[1] |=> data_ret == $past(data_bit))
    else $error("digital loop did not return input bit");
  AST_RSVD_LOW: assert property (third_control_word_out[7] == 1'b0)
    else $error("reserved control bit is set");
  AST_REFRAME_ON_FALL: assert property ($fell(third_control_word_out[0]) |-> ##[0:2] reframe_out)
    else $error("no reframe after falling control bit");
  AST_REFRAME_CAUSE: assert property (reframe_out && !third_control_word_out[3]
      |-> $past(third_control_word_out[0]) || $past(third_control_word_out[0], 2))
    else $error("reframe without a falling control bit");
  AST_REFRAME_PULSE: assert property (reframe_out |=> !reframe_out)
    else $error("reframe pulse longer than one cycle");
  AST_CW_ON_BIT: assert property ($changed(third_control_word_out) |-> $past(bit_en, 2))
    else $error("control word changed off the bus");
endmodule : e1o_props

// ### tb/e1o_framer_tb_top.sv
`timescale 1ns/100ps
module e1o_framer_tb_top;
  import e1o_pkg::*;
  localparam int BIT_DIV = 2;
  localparam int NBITS   = 8192;
  localparam int MAINT_CYC = 50;
  localparam int SEC_CYC   = 2000;
  localparam logic [5:0] MFA = 6'h0b;
  logic      ref_clk_in, nrst_in, wr_in, rd_in, rd_d, tx_data_in, rx_data_out;
  logic      rx_tip_in, rx_ring_in, rx_data_in, frame_sync_in, crc_mf_sync_in, crc_err_in;
  logic      line_out_a_out, line_out_b_out, reframe_out, smf1_in, smf2_in;
  e1o_addr_t addr_in;
  e1o_byte_t wdata_in, rdata_out, third_control_word_out, cw_prev, ex, msk;
  int        fail_count, n_compared, seed, reframe_cnt, c0, fi;
  e1o_byte_t rd_q[$];
  e1o_byte_t cw_q[$];
  e1o_byte_t sig[16];
  logic      line_bits[NBITS];
  logic [1:0] r;

  e1o_ctl_if ifc();
  e1o_controller #(.BIT_DIV(BIT_DIV)) e1o_controller_i (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .tx_data_in(tx_data_in), .rx_data_out(rx_data_out), .ifc(ifc));
  e1o_framer #(.MAINT_WAIT_CYC(MAINT_CYC), .SECOND_CYC(SEC_CYC)) e1o_framer_i (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .ifc(ifc), .rx_tip_in(rx_tip_in), .rx_ring_in(rx_ring_in),
    .rx_data_in(rx_data_in), .frame_sync_in(frame_sync_in), .crc_mf_sync_in(crc_mf_sync_in),
    .crc_err_in(crc_err_in), .smf1_result_in(smf1_in), .smf2_result_in(smf2_in),
    .line_out_a_out(line_out_a_out), .line_out_b_out(line_out_b_out),
    .reframe_out(reframe_out), .third_control_word_out(third_control_word_out));
  e1o_props #(.BIT_DIV(BIT_DIV)) e1o_props_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .bit_en(ifc.bit_en), .frame_pulse(ifc.frame_pulse), .ctl_bit(ifc.ctl_bit),
    .data_bit(ifc.data_bit), .data_ret(ifc.data_ret), .reframe_out(reframe_out),
    .third_control_word_out(third_control_word_out));

  // Free-running 50 MHz reference clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One register cycle; strobes stay as set until the next call, so no signal is driven twice.
  task automatic bus(input logic w, input logic rd, input e1o_addr_t a, input e1o_byte_t d);
    wr_in <= w;
    rd_in <= rd;
    addr_in <= a;
    wdata_in <= d;
    if (rd) rd_q.push_back(d);
    @(posedge ref_clk_in);
  endtask : bus

  task automatic end_of_test();
    $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  function automatic e1o_byte_t line_byte(input int i);
    e1o_byte_t v;
    v = '0;
    for (int b = 0; b < 8; b++) v = {v[6:0], line_bits[i + b]};
    return v;
  endfunction : line_byte

  // Read data and control word changes are matched to the oldest pending note.
  always @(posedge ref_clk_in) begin
    rd_d <= rd_in;
    cw_prev <= third_control_word_out;
    if (reframe_out === 1'b1) reframe_cnt++;
    if (rd_d) check(rdata_out, (rd_q.size() != 0) ? rd_q.pop_front() : 8'hxx);
    if (nrst_in && third_control_word_out !== cw_prev)
      check(third_control_word_out, (cw_q.size() != 0) ? cw_q.pop_front() : 8'hxx);
  end

  // Watchdog sized well past the longest expected run.
  initial begin
    repeat (90000) @(posedge ref_clk_in);
    fail_count++;
    end_of_test();
  end

  initial begin
    {wr_in, rd_in, tx_data_in, rx_tip_in, rx_ring_in, rx_data_in} = '0;
    {frame_sync_in, crc_mf_sync_in, crc_err_in, smf1_in, smf2_in} = '0;
    addr_in = '0;
    wdata_in = '0;
    seed = 6;
    nrst_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    // Reset values, refused places and the write rewrites done by the controller.
    bus(0, 1, 5'h01, 8'hdd);
    bus(0, 1, 5'h10, 8'h9b);
    bus(0, 1, 5'h11, 8'hdf);
    bus(0, 1, 5'h12, 8'h00);
    bus(1, 0, 5'h14, 8'h55);
    bus(0, 1, 5'h14, 8'h00);
    bus(0, 1, 5'h00, 8'h00);
    bus(1, 0, 5'h05, 8'h0a);
    bus(0, 1, 5'h05, 8'hda);
    bus(1, 0, 5'h12, 8'h90);
    cw_q.push_back(8'h10);
    bus(0, 1, 5'h12, 8'h10);
    for (int n = 1; n <= 15; n++) begin
      sig[n] = {4'($random(seed)) | 4'h1, 4'($random(seed))};
      bus(1, 0, 5'(n), sig[n]);
    end
    bus(0, 0, 5'h00, 8'h00);
    $display("register test done");
    // Payload all ones so only overhead can form the alignment words on the line.
    // Pass 1 adds CRC and spare-bit multiplexing; its CRC bits are not predicted.
    tx_data_in <= 1'b1;
    for (int md = 0; md < 2; md++) begin
      if (md == 1) begin
        {smf1_in, smf2_in} <= 2'($random(seed));
        bus(1, 0, 5'h12, 8'h54);
        cw_q.push_back(8'h54);
        bus(0, 0, 5'h00, 8'h00);
      end
      repeat (3000) @(posedge ref_clk_in);
      for (int i = 0; i < NBITS; i++) begin
        do @(posedge ref_clk_in); while (ifc.bit_en !== 1'b1);
        line_bits[i] = line_out_a_out | line_out_b_out;
        rx_data_in <= 1'($random(seed));
      end
      msk = md ? 8'h7f : 8'hff;
      fi = -1;
      for (int i = 0; i < NBITS - 4096; i++)
        if (fi < 0 && (line_byte(i) & msk) == (8'h9b & msk) && line_byte(i + 128) == 8'h0b &&
            (line_byte(i + 256) & msk) == (8'hdf & msk) &&
            (line_byte(i + 512) & msk) == (8'h9b & msk)) fi = i;
      check(8'(fi >= 0), 8'h01);
      if (fi >= 0) begin
        for (int n = 1; n <= 15; n++) begin
          check(line_byte(fi + 256 * n + 128), sig[n]);
          ex = (n % 2) ? 8'hdf : 8'h9b;
          msk = (md == 1 && n % 2 == 0) ? 8'h7f : 8'hff;
          if (md == 1 && n % 2 == 1)
            ex[7] = (n == 13) ? smf1_in : (n == 15) ? smf2_in : MFA[5 - n / 2];
          check(line_byte(fi + 256 * n) & msk, ex & msk);
        end
      end
      $display("line frame test done");
    end
    // Digital loop returns the transmit payload, not the received one.
    bus(1, 0, 5'h12, 8'h12);
    cw_q.push_back(8'h12);
    bus(0, 0, 5'h00, 8'h00);
    repeat (2200) @(posedge ref_clk_in);
    for (int v = 0; v < 2; v++) begin
      tx_data_in <= 1'(v);
      rx_data_in <= ~1'(v);
      repeat (300) @(posedge ref_clk_in);
      check(8'(rx_data_out), 8'(v));
    end
    $display("digital loop test done");
    // Remote loop copies tip and ring to the line outputs.
    bus(1, 0, 5'h12, 8'h30);
    cw_q.push_back(8'h30);
    bus(0, 0, 5'h00, 8'h00);
    repeat (2200) @(posedge ref_clk_in);
    for (int k = 0; k < 40; k++) begin
      r = 2'($random(seed));
      rx_tip_in <= r[1];
      rx_ring_in <= r[0];
      repeat (2) @(posedge ref_clk_in);
      check(8'({line_out_a_out, line_out_b_out}), 8'(r));
    end
    $display("remote loop test done");
    // Maintenance: multiframe timeout, then error counts at and above the limit.
    bus(1, 0, 5'h12, 8'h18);
    cw_q.push_back(8'h18);
    bus(0, 0, 5'h00, 8'h00);
    repeat (2200) @(posedge ref_clk_in);
    c0 = reframe_cnt;
    frame_sync_in <= 1'b1;
    repeat (500) @(posedge ref_clk_in);
    check(8'(reframe_cnt > c0), 8'h01);
    crc_mf_sync_in <= 1'b1;
    repeat (100) @(posedge ref_clk_in);
    for (int lim = 914; lim < 2000; lim += 986) begin
      c0 = reframe_cnt;
      crc_err_in <= 1'b1;
      repeat (lim) @(posedge ref_clk_in);
      crc_err_in <= 1'b0;
      repeat (2100) @(posedge ref_clk_in);
      check(8'(reframe_cnt > c0), 8'(lim > 914));
    end
    $display("maintenance test done");
    // A steady low force bit does nothing; one high period gives one reframe.
    bus(1, 0, 5'h12, 8'h10);
    cw_q.push_back(8'h10);
    bus(0, 0, 5'h00, 8'h00);
    repeat (2200) @(posedge ref_clk_in);
    c0 = reframe_cnt;
    repeat (1000) @(posedge ref_clk_in);
    check(8'(reframe_cnt - c0), 8'h00);
    bus(1, 0, 5'h12, 8'h11);
    cw_q.push_back(8'h11);
    cw_q.push_back(8'h10);
    bus(0, 0, 5'h00, 8'h00);
    bus(0, 1, 5'h1f, 8'h01);
    bus(0, 0, 5'h00, 8'h00);
    repeat (6000) @(posedge ref_clk_in);
    check(8'(reframe_cnt - c0), 8'h01);
    check(8'(cw_q.size()), 8'h00);
    $display("reframe test done");
    end_of_test();
  end
endmodule : e1o_framer_tb_top
